// [hw/fsol_cfg.svh]
// Behaviour
// - On every reset the stored protect byte and stored option byte are copied from flash into the working registers.
// - An eight-byte backdoor compare key is held in flash starting at the lowest key address.
// - The key may lift security only while the key enable bit reads 1, and only until the next reset.
// - Key entry is accepted only from code running in secure memory and never from background debug access.
// - With the key enable bit at 0 the key is dead and only a mass erase followed by a passing blank check unsecures.
// - The security field value 1:0 means unsecured, and software must program it before reset to stay unsecured.
// - The stored option, protect and key bytes live in the flash array, not in the high-page registers.
// - The command register accepts blank check 0x05 and mass erase 0x41 among five valid commands.
`ifndef FSOL_CFG_SVH
`define FSOL_CFG_SVH

// ***************************************
// High-page register offsets
// ***************************************
`define FSOL_ADR_CLK_DIV    16'h1820
`define FSOL_ADR_OPTION     16'h1821
`define FSOL_ADR_CONFIG     16'h1823
`define FSOL_ADR_PROTECT    16'h1824
`define FSOL_ADR_STATUS     16'h1825
`define FSOL_ADR_COMMAND    16'h1826

// ***************************************
// Flash array locations
// ***************************************
`define FSOL_ADR_KEY_BASE   16'hFFB0
`define FSOL_ADR_KEY_LAST   16'hFFB7
`define FSOL_ADR_NV_PROT    16'hFFBD
`define FSOL_ADR_NV_OPT     16'hFFBF
`define FSOL_ADR_FLASH_LO   16'hC000

// ***************************************
// Field positions
// ***************************************
`define FSOL_BIT_KEY_EN     7
`define FSOL_BIT_VEC_RED    6
`define FSOL_BIT_KEY_ACC    5
`define FSOL_BIT_DIV_LOADED 7
`define FSOL_BIT_BUF_EMPTY  7
`define FSOL_BIT_CMD_DONE   6
`define FSOL_BIT_PROT_VIOL  5
`define FSOL_BIT_ACC_ERR    4
`define FSOL_BIT_BLANK      2
`define FSOL_SEC_OPEN       2'h2

// ***************************************
// Commands
// ***************************************
`define FSOL_CMD_BLANK      8'h05
`define FSOL_CMD_PROG       8'h20
`define FSOL_CMD_BURST      8'h25
`define FSOL_CMD_PAGE_ERASE 8'h40
`define FSOL_CMD_MASS_ERASE 8'h41

// ***************************************
// Reset values and counts
// ***************************************
`define FSOL_RST_BYTE       8'h00
`define FSOL_RST_KEY        64'h0000000000000000
`define FSOL_KEY_FULL       8'hFF
`define FSOL_LD_FIRST_NV    4'h8
`define FSOL_LD_LAST_NV     4'h9
`define FSOL_LD_END         4'hA

`endif

// [hw/fsol_pkg.sv]
package fsol_pkg;

   typedef enum logic [1:0] {
      FSOL_LD_RUN,
      FSOL_LD_DONE
   } fsol_ld_e;

   typedef enum logic [1:0] {
      FSOL_PH_IDLE,
      FSOL_PH_ADDR,
      FSOL_PH_CMD
   } fsol_phase_e;

   typedef struct packed {
      fsol_ld_e    ld_state;
      logic [3:0]  ld_idx;
      logic [63:0] key_store;
      logic [7:0]  prot;
      logic [7:0]  opt;
      logic [7:0]  clk_div;
      logic        key_acc;
      logic [63:0] key_entry;
      logic [7:0]  key_mask;
      logic        unlocked;
      logic        erased;
      fsol_phase_e phase;
      logic [7:0]  cmd;
      logic [15:0] cmd_addr;
      logic [7:0]  cmd_data;
      logic        busy;
      logic        buf_empty;
      logic        cmd_done;
      logic        prot_viol;
      logic        acc_err;
      logic        blank;
      logic        cmd_start;
      logic [7:0]  rdata;
   } fsol_state_s;

endpackage : fsol_pkg

// [hw/fsol_top.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "fsol_cfg.svh"

module fsol_top
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Origin of the current access
   input  wire logic        exec_secure,
   input  wire logic        bdm_access,
   // Flash array read port
   output logic             flash_rd_en,
   output logic      [15:0] flash_rd_addr,
   input  wire logic [7:0]  flash_rd_data,
   // Flash command engine
   output logic             flash_cmd_start,
   output logic      [7:0]  flash_cmd_code,
   output logic      [15:0] flash_cmd_addr,
   output logic      [7:0]  flash_cmd_data,
   input  wire logic        flash_cmd_done,
   input  wire logic        flash_blank_ok,
   input  wire logic        flash_prot_viol,
   // Security and protection state
   output logic             load_done,
   output logic             secured,
   output logic      [7:0]  block_protect,
   output logic             vector_redirect_disable
);

   // ***************************************
   // Decoders
   // ***************************************
   function automatic logic in_key_range(input logic [15:0] a);
      in_key_range = (a >= `FSOL_ADR_KEY_BASE) && (a <= `FSOL_ADR_KEY_LAST);
   endfunction : in_key_range

   function automatic logic valid_cmd(input logic [7:0] c);
      valid_cmd = (c == `FSOL_CMD_BLANK) || (c == `FSOL_CMD_PROG) ||
                  (c == `FSOL_CMD_BURST) || (c == `FSOL_CMD_PAGE_ERASE) ||
                  (c == `FSOL_CMD_MASS_ERASE);
   endfunction : valid_cmd

   // ***************************************
   // State
   // ***************************************
   fsol_pkg::fsol_state_s st;
   fsol_pkg::fsol_state_s next_st;

   logic       key_enable_bit;
   logic       sec_open;
   logic       trusted;
   logic [3:0] cap_idx;
   logic [7:0] status_byte;

   assign key_enable_bit = st.opt[`FSOL_BIT_KEY_EN];
   // Field 1:0 is the only open code; all three other patterns mean secure
   assign sec_open       = (st.opt[1:0] == `FSOL_SEC_OPEN);
   // Debug commands never count as secure code, so no key through them
   assign trusted        = exec_secure && !bdm_access;
   assign cap_idx        = st.ld_idx - 4'h1;

   always_comb
   begin
      status_byte                       = `FSOL_RST_BYTE;
      status_byte[`FSOL_BIT_BUF_EMPTY]  = st.buf_empty;
      status_byte[`FSOL_BIT_CMD_DONE]   = st.cmd_done;
      status_byte[`FSOL_BIT_PROT_VIOL]  = st.prot_viol;
      status_byte[`FSOL_BIT_ACC_ERR]    = st.acc_err;
      status_byte[`FSOL_BIT_BLANK]      = st.blank;
   end

   // ***************************************
   // Reset-time load from the flash array
   // ***************************************
   // One address per cycle; data returns the next cycle and is captured one index behind
   always_comb
   begin
      flash_rd_en   = (st.ld_state == fsol_pkg::FSOL_LD_RUN) && (st.ld_idx != `FSOL_LD_END);
      flash_rd_addr = `FSOL_ADR_KEY_BASE + {12'h000, st.ld_idx};
      if (st.ld_idx == `FSOL_LD_FIRST_NV)
      begin
         flash_rd_addr = `FSOL_ADR_NV_PROT;
      end
      else if (st.ld_idx == `FSOL_LD_LAST_NV)
      begin
         flash_rd_addr = `FSOL_ADR_NV_OPT;
      end
   end

   // ***************************************
   // Next-state logic
   // ***************************************
   always_comb
   begin
      next_st           = st;
      next_st.cmd_start = 1'b0;
      next_st.rdata     = `FSOL_RST_BYTE;

      case (st.ld_state)
         fsol_pkg::FSOL_LD_RUN:
         begin
            if (st.ld_idx != 4'h0)
            begin
               if (cap_idx < `FSOL_LD_FIRST_NV)
               begin
                  next_st.key_store[{cap_idx[2:0], 3'h0} +: 8] = flash_rd_data;
               end
               else if (cap_idx == `FSOL_LD_FIRST_NV)
               begin
                  next_st.prot = flash_rd_data;
               end
               else
               begin
                  next_st.opt = flash_rd_data;
               end
            end
            if (st.ld_idx == `FSOL_LD_END)
            begin
               next_st.ld_state = fsol_pkg::FSOL_LD_DONE;
            end
            else
            begin
               next_st.ld_idx = st.ld_idx + 4'h1;
            end
         end
         fsol_pkg::FSOL_LD_DONE:
         begin
            next_st.ld_idx = st.ld_idx;
         end
         default:
         begin
            next_st.ld_state = fsol_pkg::FSOL_LD_RUN;
         end
      endcase

      // ***************************************
      // Register reads
      // ***************************************
      if (reg_rd)
      begin
         case (reg_addr)
            `FSOL_ADR_CLK_DIV: next_st.rdata = st.clk_div;
            `FSOL_ADR_OPTION:  next_st.rdata = st.opt;
            `FSOL_ADR_CONFIG:  next_st.rdata[`FSOL_BIT_KEY_ACC] = st.key_acc;
            `FSOL_ADR_PROTECT: next_st.rdata = st.prot;
            `FSOL_ADR_STATUS:  next_st.rdata = status_byte;
            `FSOL_ADR_COMMAND: next_st.rdata = st.cmd;
            default:           next_st.rdata = `FSOL_RST_BYTE;
         endcase
      end

      // ***************************************
      // Register and array writes
      // ***************************************
      if (reg_wr)
      begin
         case (reg_addr)
            `FSOL_ADR_CLK_DIV:
            begin
               // Write-once, and locked out while an access error stands
               if (!st.clk_div[`FSOL_BIT_DIV_LOADED] && !st.acc_err)
               begin
                  next_st.clk_div                       = reg_wdata;
                  next_st.clk_div[`FSOL_BIT_DIV_LOADED] = 1'b1;
               end
            end
            `FSOL_ADR_CONFIG:
            begin
               if (trusted && key_enable_bit)
               begin
                  next_st.key_acc = reg_wdata[`FSOL_BIT_KEY_ACC];
                  if (st.key_acc && !reg_wdata[`FSOL_BIT_KEY_ACC])
                  begin
                     // Compare on leaving key mode; a partial entry never matches
                     if ((st.key_mask == `FSOL_KEY_FULL) && (st.key_entry == st.key_store))
                     begin
                        next_st.unlocked = 1'b1;
                     end
                     next_st.key_mask = `FSOL_RST_BYTE;
                  end
               end
            end
            `FSOL_ADR_PROTECT:
            begin
               next_st.prot = reg_wdata;
            end
            `FSOL_ADR_STATUS:
            begin
               if (reg_wdata[`FSOL_BIT_PROT_VIOL])
               begin
                  next_st.prot_viol = 1'b0;
               end
               if (reg_wdata[`FSOL_BIT_ACC_ERR])
               begin
                  next_st.acc_err = 1'b0;
               end
               if (reg_wdata[`FSOL_BIT_BUF_EMPTY])
               begin
                  if (st.phase == fsol_pkg::FSOL_PH_CMD)
                  begin
                     if (st.clk_div[`FSOL_BIT_DIV_LOADED])
                     begin
                        next_st.buf_empty = 1'b0;
                        next_st.cmd_done  = 1'b0;
                        next_st.blank     = 1'b0;
                        next_st.busy      = 1'b1;
                        next_st.cmd_start = 1'b1;
                     end
                     else
                     begin
                        next_st.acc_err = 1'b1;
                     end
                     next_st.phase = fsol_pkg::FSOL_PH_IDLE;
                  end
                  else if (st.phase == fsol_pkg::FSOL_PH_ADDR)
                  begin
                     next_st.acc_err = 1'b1;
                     next_st.phase   = fsol_pkg::FSOL_PH_IDLE;
                  end
               end
               else if (st.phase != fsol_pkg::FSOL_PH_IDLE)
               begin
                  // Writing 0 mid-sequence aborts it
                  next_st.acc_err = 1'b1;
                  next_st.phase   = fsol_pkg::FSOL_PH_IDLE;
               end
            end
            `FSOL_ADR_COMMAND:
            begin
               if ((st.phase == fsol_pkg::FSOL_PH_ADDR) && valid_cmd(reg_wdata))
               begin
                  next_st.cmd   = reg_wdata;
                  next_st.phase = fsol_pkg::FSOL_PH_CMD;
               end
               else
               begin
                  next_st.acc_err = 1'b1;
                  next_st.phase   = fsol_pkg::FSOL_PH_IDLE;
               end
            end
            default:
            begin
               if (st.key_acc && in_key_range(reg_addr))
               begin
                  // Key mode turns array writes into key bytes, never a command
                  if (trusted && key_enable_bit)
                  begin
                     next_st.key_entry[{reg_addr[2:0], 3'h0} +: 8] = reg_wdata;
                     next_st.key_mask[reg_addr[2:0]]               = 1'b1;
                  end
               end
               else if (!st.key_acc && (reg_addr >= `FSOL_ADR_FLASH_LO))
               begin
                  if ((st.phase == fsol_pkg::FSOL_PH_IDLE) && st.buf_empty && !st.busy)
                  begin
                     next_st.cmd_addr = reg_addr;
                     next_st.cmd_data = reg_wdata;
                     next_st.phase    = fsol_pkg::FSOL_PH_ADDR;
                  end
                  else
                  begin
                     next_st.acc_err = 1'b1;
                     next_st.phase   = fsol_pkg::FSOL_PH_IDLE;
                  end
               end
            end
         endcase
      end

      // ***************************************
      // Command completion
      // ***************************************
      // Placed after the writes so a hardware set beats a same-cycle clear
      if (flash_cmd_done && st.busy)
      begin
         next_st.busy      = 1'b0;
         next_st.buf_empty = 1'b1;
         next_st.cmd_done  = 1'b1;
         if (flash_prot_viol)
         begin
            next_st.prot_viol = 1'b1;
         end
         if (st.cmd == `FSOL_CMD_MASS_ERASE)
         begin
            next_st.erased = 1'b1;
         end
         if (st.cmd == `FSOL_CMD_BLANK)
         begin
            next_st.blank = flash_blank_ok;
            // Only an erase that is then proven blank opens a keyless part
            if (flash_blank_ok && st.erased)
            begin
               next_st.unlocked = 1'b1;
            end
         end
      end
   end

   // ***************************************
   // State register
   // ***************************************
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st           <= '0;
         st.ld_state  <= fsol_pkg::FSOL_LD_RUN;
         st.phase     <= fsol_pkg::FSOL_PH_IDLE;
         st.key_store <= `FSOL_RST_KEY;
         st.unlocked  <= 1'b0;
         st.buf_empty <= 1'b1;
         st.cmd_done  <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign reg_rdata               = st.rdata;
   assign flash_cmd_start         = st.cmd_start;
   assign flash_cmd_code          = st.cmd;
   assign flash_cmd_addr          = st.cmd_addr;
   assign flash_cmd_data          = st.cmd_data;
   assign load_done               = (st.ld_state == fsol_pkg::FSOL_LD_DONE);
   // Secure until the load finishes, so nothing leaks in the first cycles
   assign secured                 = !load_done || (!sec_open && !st.unlocked);
   assign block_protect           = st.prot;
   assign vector_redirect_disable = st.opt[`FSOL_BIT_VEC_RED];

endmodule : fsol_top
`default_nettype wire

// [test/fsol_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsol_cfg.svh"

// ***************************************
// Flash array and command engine stand-in
// ***************************************
module fsol_flash_model
#(
   parameter logic [63:0] KEY   = 64'h1F2E3D4C5B6A7988,
   parameter logic [7:0]  PROT  = 8'hC4,
   parameter int          DELAY = 6
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // Read port
   input  wire logic        rd_en,
   input  wire logic [15:0] rd_addr,
   output logic      [7:0]  rd_data,
   input  wire logic [7:0]  opt_byte,
   // Command engine
   input  wire logic        cmd_start,
   output logic             cmd_done,
   output logic             blank_ok,
   output logic             prot_viol
);
   int cnt;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_data <= 8'h00;
         cnt <= 0;
         {cmd_done, blank_ok, prot_viol} <= 3'h0;
      end
      else
      begin
         // Undriven read data toggles so a late capture shows up
         if (!rd_en) rd_data <= ~rd_data;
         else if (rd_addr[15:3] == 13'h1FF6) rd_data <= KEY[8*rd_addr[2:0] +: 8];
         else if (rd_addr == `FSOL_ADR_NV_PROT) rd_data <= PROT;
         else if (rd_addr == `FSOL_ADR_NV_OPT) rd_data <= opt_byte;
         else rd_data <= ~rd_data;
         cnt <= cmd_start ? DELAY : (cnt > 0 ? cnt - 1 : 0);
         cmd_done <= (cnt == 1);
         // Qualifiers only mean something beside done
         blank_ok <= (cnt == 1) ? 1'b1 : ~blank_ok;
         prot_viol <= (cnt == 1) ? 1'b0 : ~prot_viol;
      end
   end
endmodule : fsol_flash_model

`default_nettype wire

// [test/fsol_props.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsol_cfg.svh"

module fsol_props
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        exec_secure,
   input  wire logic        bdm_access,
   // Flash side
   input  wire logic        flash_rd_en,
   input  wire logic [15:0] flash_rd_addr,
   input  wire logic        flash_cmd_start,
   input  wire logic [7:0]  flash_cmd_code,
   input  wire logic        flash_cmd_done,
   // State
   input  wire logic        load_done,
   input  wire logic        secured
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // ***************************************
   // Causes of a lift, one cycle back
   // ***************************************
   logic close_q, done_q, ld_q;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n) {close_q, done_q, ld_q} <= 3'h0;
      else {close_q, done_q, ld_q} <= {reg_wr && reg_addr == `FSOL_ADR_CONFIG && exec_secure && !bdm_access,
                                        flash_cmd_done, !load_done};
   end

   // Option byte is the last read, so the working option never opens before it is captured
   AST_OPT_LAST: assert property (flash_rd_en && flash_rd_addr == `FSOL_ADR_NV_OPT
      |=> !load_done ##1 load_done) else $error("option byte not loaded last");
   AST_LOAD_TIME: assert property ($rose(arst_n) |-> ##[1:12] load_done) else $error("load late");
   AST_LOAD_HOLD: assert property (load_done |=> load_done && !flash_rd_en) else $error("load restarted");
   AST_NV_ADDR: assert property (flash_rd_en |-> flash_rd_addr[15:4] == 12'hFFB) else $error("load addr");
   AST_BDM_KEY: assert property (reg_wr && bdm_access && secured && load_done && !flash_cmd_done
      |=> secured) else $error("debug write lifted security");
   AST_SEC_STICK: assert property (!secured && load_done |=> !secured) else $error("security returned");
   AST_LIFT_CAUSE: assert property ($fell(secured) |-> close_q || done_q || ld_q)
      else $error("security lifted without cause");
   AST_START_PULSE: assert property (flash_cmd_start |=> !flash_cmd_start)
      else $error("start not a pulse");
   AST_START_CODE: assert property (flash_cmd_start |->
      flash_cmd_code inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("bad command launched");

   COV_LIFT: cover property ($fell(secured));
   COV_MASS: cover property (flash_cmd_start && flash_cmd_code == `FSOL_CMD_MASS_ERASE);
   COV_BLANK: cover property (flash_cmd_start && flash_cmd_code == `FSOL_CMD_BLANK);
endmodule : fsol_props

bind fsol_top fsol_props u_fsol_props
(
   .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .exec_secure(exec_secure), .bdm_access(bdm_access), .flash_rd_en(flash_rd_en),
   .flash_rd_addr(flash_rd_addr), .flash_cmd_start(flash_cmd_start), .flash_cmd_code(flash_cmd_code),
   .flash_cmd_done(flash_cmd_done), .load_done(load_done), .secured(secured)
);

`default_nettype wire

// [test/fsol_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsol_cfg.svh"

module fsol_top_tb;
   localparam logic [63:0] KEY  = 64'h1F2E3D4C5B6A7988;
   localparam logic [7:0]  PROT = 8'hC4;

   logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, exec_secure = 1'b0, bdm_access = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, opt_byte = 8'hC3;
   logic [7:0]  reg_rdata, flash_rd_data, flash_cmd_code, flash_cmd_data, block_protect;
   logic [15:0] flash_rd_addr, flash_cmd_addr;
   logic flash_rd_en, flash_cmd_start, flash_cmd_done, flash_blank_ok, flash_prot_viol;
   logic load_done, secured, vector_redirect_disable;
   int bad_count = 0, checks = 0;

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("Error at %0t: mismatch got %h exp %h", $time, got, exp); end end

   always #20 ref_clk = ~ref_clk;

   fsol_top u_fsol_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_secure(exec_secure),
      .bdm_access(bdm_access), .flash_rd_en(flash_rd_en), .flash_rd_addr(flash_rd_addr),
      .flash_rd_data(flash_rd_data), .flash_cmd_start(flash_cmd_start), .flash_cmd_code(flash_cmd_code),
      .flash_cmd_addr(flash_cmd_addr), .flash_cmd_data(flash_cmd_data), .flash_cmd_done(flash_cmd_done),
      .flash_blank_ok(flash_blank_ok),
      .flash_prot_viol(flash_prot_viol), .load_done(load_done), .secured(secured),
      .block_protect(block_protect), .vector_redirect_disable(vector_redirect_disable));

   fsol_flash_model #(.KEY(KEY), .PROT(PROT), .DELAY(6)) u_fsol_flash_model (.ref_clk(ref_clk),
      .arst_n(arst_n), .rd_en(flash_rd_en), .rd_addr(flash_rd_addr), .rd_data(flash_rd_data),
      .opt_byte(opt_byte), .cmd_start(flash_cmd_start), .cmd_done(flash_cmd_done),
      .blank_ok(flash_blank_ok), .prot_viol(flash_prot_viol));

   // ***************************************
   // Bus tasks
   // ***************************************
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] mask);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata & mask, exp)
   endtask : rd

   task automatic do_reset(input logic [7:0] opt);
      int n;
      @(posedge ref_clk);
      arst_n <= 1'b0; opt_byte <= opt;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (n = 0; n < 20 && load_done !== 1'b1; n++)
      begin
         @(posedge ref_clk);
         #1;
      end
      `CHK(load_done, 1'b1)
   endtask : do_reset

   // Opening write of key mode is what an untrusted origin must not reach
   task automatic key_try(input logic [63:0] k, input logic s, input logic b, input logic exp);
      int i;
      @(posedge ref_clk);
      exec_secure <= s; bdm_access <= b;
      wr(`FSOL_ADR_CONFIG, 8'h20);
      for (i = 0; i < 8; i++) wr(`FSOL_ADR_KEY_BASE + 16'(i), k[8*i +: 8]);
      wr(`FSOL_ADR_CONFIG, 8'h00);
      #1 `CHK(secured, exp)
   endtask : key_try

   task automatic cmd(input logic [7:0] code);
      int n;
      wr(`FSOL_ADR_FLASH_LO, code);
      wr(`FSOL_ADR_COMMAND, code);
      wr(`FSOL_ADR_STATUS, 8'h80);
      #1 `CHK(flash_cmd_start, 1'b1)
      `CHK(flash_cmd_code, code)
      `CHK(flash_cmd_addr, `FSOL_ADR_FLASH_LO)
      `CHK(flash_cmd_data, code)
      for (n = 0; n < 40 && flash_cmd_done !== 1'b1; n++)
      begin
         @(posedge ref_clk);
         #1;
      end
      `CHK(flash_cmd_done, 1'b1)
      rd(`FSOL_ADR_STATUS, 8'hC0, 8'hC0);
   endtask : cmd

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (6000) @(posedge ref_clk);
      bad_count++;
      final_report();
   end

   // ***************************************
   // Tests
   // ***************************************
   initial
   begin
      do_reset(8'hC3);
      rd(`FSOL_ADR_OPTION, 8'hC3, 8'hFF);
      rd(`FSOL_ADR_PROTECT, PROT, 8'hFF);
      `CHK(block_protect, PROT)
      `CHK(vector_redirect_disable, 1'b1)
      `CHK(secured, 1'b1)
      rd(16'h1822, 8'h00, 8'hFF);
      wr(`FSOL_ADR_OPTION, 8'h00);
      rd(`FSOL_ADR_OPTION, 8'hC3, 8'hFF);
      $display("test reset load done");
      key_try(KEY, 1'b1, 1'b1, 1'b1);
      key_try(KEY, 1'b0, 1'b0, 1'b1);
      key_try(KEY ^ 64'h0000000000000100, 1'b1, 1'b0, 1'b1);
      key_try(KEY, 1'b1, 1'b0, 1'b0);
      do_reset(8'hC3);
      `CHK(secured, 1'b1)
      $display("test backdoor key done");
      do_reset(8'h01);
      key_try(KEY, 1'b1, 1'b0, 1'b1);
      // Refused key bytes fall through as array writes and leave an access error, cleared before the write-once divider is set
      rd(`FSOL_ADR_STATUS, 8'h10, 8'h10);
      wr(`FSOL_ADR_STATUS, 8'h10);
      rd(`FSOL_ADR_STATUS, 8'h00, 8'h10);
      wr(`FSOL_ADR_CLK_DIV, 8'h13);
      rd(`FSOL_ADR_CLK_DIV, 8'h93, 8'hFF);
      wr(`FSOL_ADR_CLK_DIV, 8'h05);
      rd(`FSOL_ADR_CLK_DIV, 8'h93, 8'hFF);
      cmd(`FSOL_CMD_MASS_ERASE);
      `CHK(secured, 1'b1)
      cmd(`FSOL_CMD_BLANK);
      `CHK(secured, 1'b0)
      wr(`FSOL_ADR_FLASH_LO, 8'h00);
      wr(`FSOL_ADR_COMMAND, 8'h11);
      rd(`FSOL_ADR_STATUS, 8'h10, 8'h10);
      wr(`FSOL_ADR_STATUS, 8'h10);
      rd(`FSOL_ADR_STATUS, 8'h00, 8'h10);
      $display("test keyless unlock done");
      do_reset(8'h02);
      `CHK(secured, 1'b0)
      rd(`FSOL_ADR_OPTION, 8'h02, 8'hFF);
      $display("test open option done");
      final_report();
   end
endmodule : fsol_top_tb

`default_nettype wire
